// ==== rtl/isc_defs.vh ====
/*
 * Constants for the interrupt and sleep controller: register offsets, field positions,
 * reset values, vector addresses, sense codes and timing figures.
 * Assumes inclusion by bare name from a file compiled after it.
 */
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH
`define ISC_ADR_CPU_CTRL    8'h35
`define ISC_ADR_TMR_FLAGS   8'h38
`define ISC_ADR_TMR_MASK    8'h39
`define ISC_ADR_PIN_MASK    8'h3B
`define ISC_ADR_STATUS      8'h3F
`define ISC_BIT_PIN_EN      6
`define ISC_BIT_OVF         1
`define ISC_BIT_SLP_EN      5
`define ISC_BIT_SLP_DEPTH   4
`define ISC_BIT_GIE         7
`define ISC_SENSE_LO        0
`define ISC_SENSE_HI        1
`define ISC_SENSE_LEVEL     2'h0
`define ISC_SENSE_FALL      2'h2
`define ISC_SENSE_RISE      2'h3
`define ISC_CTRL_MASK       8'h33
`define ISC_RESET_BYTE      8'h00
`define ISC_VEC_RESET       9'h000
`define ISC_VEC_PIN         9'h001
`define ISC_VEC_OVF         9'h002
`define ISC_VEC_CMP         9'h003
`define ISC_ENTRY_CYCLES    3'h4
`define ISC_RETURN_CYCLES   3'h4
`define ISC_CNT_ONE         3'h1
`define ISC_PC_WIDTH        9
`define ISC_STACK_DEPTH     3
`define ISC_STACK_FULL      2'h3
`endif

// ==== rtl/isc_irq_sleep.v ====
/*
 * Interrupt and sleep controller: Wishbone register slave, pin sense logic, overflow flag,
 * priority arbiter with entry and return sequencing, three-entry return stack, sleep control.
 * Assumes the CPU core reports instruction boundaries, calls, returns and sleep, and that the
 * pin and watchdog inputs are asynchronous while timer and comparator events share clk_i.
 */
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "isc_defs.vh"
module isc_irq_sleep (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       cyc_i,
    input  wire       stb_i,
    input  wire       we_i,
    input  wire [7:0] adr_i,
    input  wire [7:0] dat_i,
    input  wire       sel_i,
    output reg  [7:0] dat_o,
    output reg        ack_o,
    output reg        err_o,
    input  wire       ext_irq_pin_i,
    input  wire       wdt_wake_i,
    input  wire       timer_ovf_i,
    input  wire       cmp_event_i,
    input  wire       instr_done_i,
    input  wire [8:0] pc_i,
    input  wire       call_i,
    input  wire       ret_i,
    input  wire       irq_return_instruction_i,
    input  wire       sleep_instr_i,
    output reg        cpu_halt_o,
    output reg        osc_stop_o,
    output reg        vector_valid_o,
    output reg  [8:0] vector_pc_o,
    output reg        return_valid_o,
    output reg  [8:0] return_pc_o,
    output reg        global_enable_o
);
    localparam ST_RUN   = 2'h0;
    localparam ST_ENTRY = 2'h1;
    localparam ST_RET   = 2'h2;
    localparam ST_SLEEP = 2'h3;

    reg [1:0] state;
    reg [2:0] cnt;
    reg [1:0] pin_sync;
    reg [1:0] wdt_sync;
    reg       pin_prev;
    reg       edge_pend;
    reg       overflow_flag;
    reg       cmp_flag;
    reg       ovf_irq_enable;
    reg       pin_irq_enable;
    reg       sleep_enable_bit;
    reg       sleep_depth_select;
    reg [1:0] pin_sense;
    reg       hold_one;
    reg [8:0] vec_sel;
    reg [8:0] stack_mem [0:`ISC_STACK_DEPTH-1];
    reg [1:0] stack_cnt;

    wire pin_now   = pin_sync[1];
    wire level_req = (pin_sense == `ISC_SENSE_LEVEL) & ~pin_now;
    wire pin_req   = level_req | edge_pend;
    wire pin_go    = pin_req & pin_irq_enable & global_enable_o;
    wire ovf_go    = overflow_flag & ovf_irq_enable & global_enable_o;
    wire cmp_go    = cmp_flag & global_enable_o;
    wire any_go    = pin_go | ovf_go | cmp_go;
    wire acc       = cyc_i & stb_i & ~ack_o & ~err_o;
    wire wr        = acc & we_i & sel_i;
    wire hit       = (adr_i == `ISC_ADR_CPU_CTRL) | (adr_i == `ISC_ADR_TMR_FLAGS) |
                     (adr_i == `ISC_ADR_TMR_MASK) | (adr_i == `ISC_ADR_PIN_MASK) |
                     (adr_i == `ISC_ADR_STATUS);
    wire wr_flags  = wr & (adr_i == `ISC_ADR_TMR_FLAGS);
    wire wr_status = wr & (adr_i == `ISC_ADR_STATUS);
    wire take      = (state == ST_RUN) & instr_done_i & ~hold_one & any_go;
    // Power-down only wakes from a low level on the pin or from the watchdog, not from a latched edge.
    wire wake_pd   = (level_req & pin_irq_enable) | wdt_sync[1];
    wire wake      = sleep_depth_select ? wake_pd : (any_go | wdt_sync[1]);

    // Pin and watchdog wake are sampled into clk_i before use; pin direction is irrelevant.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync <= 2'h3;
            wdt_sync <= 2'h0;
            pin_prev <= 1'b1;
        end else begin
            pin_sync <= {pin_sync[0], ext_irq_pin_i};
            wdt_sync <= {wdt_sync[0], wdt_wake_i};
            pin_prev <= pin_now;
        end
    end

    always @* begin
        if (pin_go)
            vec_sel = `ISC_VEC_PIN;
        else if (ovf_go)
            vec_sel = `ISC_VEC_OVF;
        else
            vec_sel = `ISC_VEC_CMP;
    end

    // Flags and the edge latch: a new event in the clearing cycle wins over the clear.
    always @(posedge clk_i) begin
        if (rst_i) begin
            edge_pend     <= 1'b0;
            overflow_flag <= 1'b0;
            cmp_flag      <= 1'b0;
        end else begin
            if (pin_sense == `ISC_SENSE_LEVEL)
                edge_pend <= 1'b0;
            else if ((pin_sense == `ISC_SENSE_FALL && pin_prev && !pin_now) ||
                     (pin_sense == `ISC_SENSE_RISE && !pin_prev && pin_now))
                edge_pend <= 1'b1;
            else if (take && vec_sel == `ISC_VEC_PIN)
                edge_pend <= 1'b0;
            if (timer_ovf_i)
                overflow_flag <= 1'b1;
            else if ((take && vec_sel == `ISC_VEC_OVF) || (wr_flags && dat_i[`ISC_BIT_OVF]))
                overflow_flag <= 1'b0;
            if (cmp_event_i)
                cmp_flag <= 1'b1;
            else if (take && vec_sel == `ISC_VEC_CMP)
                cmp_flag <= 1'b0;
        end
    end

    // Control registers and bus answer; ack or err is given one cycle after the request.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ovf_irq_enable     <= 1'b0;
            pin_irq_enable     <= 1'b0;
            sleep_enable_bit   <= 1'b0;
            sleep_depth_select <= 1'b0;
            pin_sense          <= `ISC_SENSE_LEVEL;
            ack_o              <= 1'b0;
            err_o              <= 1'b0;
            dat_o              <= `ISC_RESET_BYTE;
        end else begin
            ack_o <= acc & hit;
            err_o <= acc & ~hit;
            if (wr && adr_i == `ISC_ADR_CPU_CTRL) begin
                sleep_enable_bit   <= dat_i[`ISC_BIT_SLP_EN];
                sleep_depth_select <= dat_i[`ISC_BIT_SLP_DEPTH];
                pin_sense          <= {dat_i[`ISC_SENSE_HI], dat_i[`ISC_SENSE_LO]};
            end
            if (wr && adr_i == `ISC_ADR_TMR_MASK)
                ovf_irq_enable <= dat_i[`ISC_BIT_OVF];
            if (wr && adr_i == `ISC_ADR_PIN_MASK)
                pin_irq_enable <= dat_i[`ISC_BIT_PIN_EN];
            dat_o <= `ISC_RESET_BYTE;
            if (acc && !we_i) begin
                case (adr_i)
                    `ISC_ADR_CPU_CTRL: begin
                        dat_o <= {2'h0, sleep_enable_bit, sleep_depth_select, 2'h0, pin_sense};
                    end
                    `ISC_ADR_TMR_FLAGS: begin
                        dat_o <= {6'h00, overflow_flag, 1'b0};
                    end
                    `ISC_ADR_TMR_MASK: begin
                        dat_o <= {6'h00, ovf_irq_enable, 1'b0};
                    end
                    `ISC_ADR_PIN_MASK: begin
                        dat_o <= {1'b0, pin_irq_enable, 6'h00};
                    end
                    `ISC_ADR_STATUS: begin
                        dat_o <= {global_enable_o, 7'h00};
                    end
                    default: begin
                        dat_o <= `ISC_RESET_BYTE;
                    end
                endcase
            end
        end
    end

    // Three-entry stack as a shift register: a fourth push drops the oldest entry.
    // The neighbour index is resolved per entry so no out-of-range element is ever named.
    genvar gi;
    generate
        for (gi = 0; gi < `ISC_STACK_DEPTH; gi = gi + 1) begin : g_stack
            wire [8:0] push_src;
            wire [8:0] pop_src;
            if (gi == 0) begin : g_first
                assign push_src = pc_i;
            end else begin : g_inner
                assign push_src = stack_mem[gi-1];
            end
            if (gi == `ISC_STACK_DEPTH-1) begin : g_last
                assign pop_src = stack_mem[gi];
            end else begin : g_upper
                assign pop_src = stack_mem[gi+1];
            end
            always @(posedge clk_i) begin
                if (rst_i)
                    stack_mem[gi] <= `ISC_VEC_RESET;
                else if (take || (state == ST_RUN && call_i))
                    stack_mem[gi] <= push_src;
                else if ((state == ST_RUN && ret_i) || (state == ST_RET && cnt == `ISC_CNT_ONE))
                    stack_mem[gi] <= pop_src;
            end
        end
    endgenerate

    // Entry, return and sleep sequencer.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state           <= ST_RUN;
            cnt             <= 3'h0;
            stack_cnt       <= 2'h0;
            hold_one        <= 1'b0;
            global_enable_o <= 1'b0;
            cpu_halt_o      <= 1'b0;
            osc_stop_o      <= 1'b0;
            vector_valid_o  <= 1'b0;
            vector_pc_o     <= `ISC_VEC_RESET;
            return_valid_o  <= 1'b0;
            return_pc_o     <= `ISC_VEC_RESET;
        end else begin
            vector_valid_o <= 1'b0;
            return_valid_o <= 1'b0;
            if (wr_status)
                global_enable_o <= dat_i[`ISC_BIT_GIE];
            if (state == ST_RUN && instr_done_i)
                hold_one <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (take) begin
                        global_enable_o <= 1'b0;
                        vector_pc_o     <= vec_sel;
                        cnt             <= `ISC_ENTRY_CYCLES;
                        state           <= ST_ENTRY;
                        cpu_halt_o      <= 1'b1;
                        if (stack_cnt != `ISC_STACK_FULL)
                            stack_cnt <= stack_cnt + 2'h1;
                    end else if (irq_return_instruction_i) begin
                        cnt        <= `ISC_RETURN_CYCLES;
                        state      <= ST_RET;
                        cpu_halt_o <= 1'b1;
                    end else if (sleep_instr_i && sleep_enable_bit) begin
                        state      <= ST_SLEEP;
                        cpu_halt_o <= 1'b1;
                        osc_stop_o <= sleep_depth_select;
                    end else if (call_i && stack_cnt != `ISC_STACK_FULL) begin
                        stack_cnt <= stack_cnt + 2'h1;
                    end else if (ret_i && stack_cnt != 2'h0) begin
                        stack_cnt <= stack_cnt - 2'h1;
                    end
                end
                ST_ENTRY: begin
                    cnt <= cnt - `ISC_CNT_ONE;
                    if (cnt == `ISC_CNT_ONE) begin
                        vector_valid_o <= 1'b1;
                        cpu_halt_o     <= 1'b0;
                        state          <= ST_RUN;
                    end
                end
                ST_RET: begin
                    cnt <= cnt - `ISC_CNT_ONE;
                    if (cnt == `ISC_CNT_ONE) begin
                        return_valid_o  <= 1'b1;
                        return_pc_o     <= stack_mem[0];
                        global_enable_o <= 1'b1;
                        hold_one        <= 1'b1;
                        cpu_halt_o      <= 1'b0;
                        state           <= ST_RUN;
                        if (stack_cnt != 2'h0)
                            stack_cnt <= stack_cnt - 2'h1;
                    end
                end
                ST_SLEEP: begin
                    // Waking returns to run; the pending interrupt is then taken at the next boundary.
                    if (wake) begin
                        state      <= ST_RUN;
                        cpu_halt_o <= 1'b0;
                        osc_stop_o <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end
endmodule // isc_irq_sleep

// ==== tb/isc_cpu_model.sv ====
/* Behavioural CPU core facing the controller: instruction boundaries and program counter.
   Assumes the controller's halt output stalls it and its vector and return outputs steer it. */
`timescale 1ns/100ps
module isc_cpu_model (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       slow_i,
    input  wire       halt_i,
    input  wire       vec_valid_i,
    input  wire [8:0] vec_pc_i,
    input  wire       ret_valid_i,
    input  wire [8:0] ret_pc_i,
    output reg        done_o,
    output reg  [8:0] pc_o
);
    reg phase;
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase <= 1'b0;
            done_o <= 1'b0;
            pc_o <= 9'h000;
        end else begin
            phase <= ~phase;
            // Two-cycle instructions report their boundary only at the end.
            done_o <= !halt_i && (!slow_i || phase);
            if (vec_valid_i)
                pc_o <= vec_pc_i;
            else if (ret_valid_i)
                pc_o <= ret_pc_i;
            else if (done_o)
                pc_o <= pc_o + 9'h001;
        end
    end
endmodule // isc_cpu_model

// ==== tb/isc_irq_sleep_sva.sv ====
/* Port checker for the interrupt and sleep controller.
   Assumes it is bound to isc_irq_sleep and sees only that module's ports. */
`timescale 1ns/100ps
module isc_irq_sleep_sva (
    input wire       clk_i,
    input wire       rst_i,
    input wire       cyc_i,
    input wire       stb_i,
    input wire [7:0] dat_o,
    input wire       ack_o,
    input wire       err_o,
    input wire       irq_return_instruction_i,
    input wire       cpu_halt_o,
    input wire       osc_stop_o,
    input wire       vector_valid_o,
    input wire [8:0] vector_pc_o,
    input wire       return_valid_o,
    input wire       global_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held over one cycle");
    chk_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
        else $error("bus request not answered in one cycle");
    chk_read_quiet: assert property (!ack_o |-> dat_o == 8'h00) else $error("read data outside ack");
    chk_vec_gie: assert property (vector_valid_o |-> !global_enable_o) else $error("global enable set at vector");
    chk_vec_code: assert property (vector_valid_o |-> vector_pc_o != 9'h000 && vector_pc_o <= 9'h003)
        else $error("vector address out of range");
    chk_entry_halted: assert property (vector_valid_o |-> $past(cpu_halt_o, 1) && $past(cpu_halt_o, 3))
        else $error("vector without entry stall");
    chk_ret_halted: assert property (return_valid_o |-> $past(cpu_halt_o, 1) && $past(cpu_halt_o, 3))
        else $error("return without stall");
    chk_ret_bound: assert property (irq_return_instruction_i && !cpu_halt_o |-> ##[2:8] return_valid_o)
        else $error("return not completed in time");
    chk_ret_gie: assert property (return_valid_o |-> ##[0:1] global_enable_o)
        else $error("return left global enable clear");
    chk_osc_halt: assert property (osc_stop_o |-> cpu_halt_o) else $error("oscillator stopped while running");
    cover property (vector_valid_o && vector_pc_o == 9'h001);
    cover property (vector_valid_o && vector_pc_o == 9'h002);
    cover property (return_valid_o);
    cover property (osc_stop_o);
endmodule // isc_irq_sleep_sva
bind isc_irq_sleep isc_irq_sleep_sva u_isc_irq_sleep_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq_return_instruction_i(irq_return_instruction_i), .cpu_halt_o(cpu_halt_o),
    .osc_stop_o(osc_stop_o), .vector_valid_o(vector_valid_o), .vector_pc_o(vector_pc_o),
    .return_valid_o(return_valid_o), .global_enable_o(global_enable_o));

// ==== tb/tb_isc_irq_sleep.sv ====
/* Testbench for the interrupt and sleep controller: register tasks and event scenarios.
   Assumes the CPU model supplies instruction boundaries and the bench plays software and pin. */
`timescale 1ns/100ps
module tb_isc_irq_sleep;
    logic       clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, slow = 1'b0;
    logic       ext_irq_pin_i = 1'b1, timer_ovf_i = 1'b0, irq_return_instruction_i = 1'b0, sleep_instr_i = 1'b0;
    logic       ack_o, err_o, instr_done_i, cpu_halt_o, osc_stop_o, vector_valid_o, return_valid_o;
    logic       global_enable_o, erf, hit;
    logic [7:0] adr_i = 8'h00, dat_i = 8'h00, dat_o, q;
    logic [8:0] pc_i, vector_pc_o, return_pc_o, last_pc = 9'h000, ret_exp = 9'h000;
    logic [7:0] am [5] = '{8'h35, 8'h38, 8'h39, 8'h3B, 8'h3F};
    logic [7:0] em [5] = '{8'h33, 8'h00, 8'h02, 8'h40, 8'h80};
    logic [7:0] sv [3] = '{8'h02, 8'h03, 8'h01};
    logic [8:0] ev [3] = '{9'h001, 9'h001, 9'h1FF};
    int         n_fail = 0, cmp_count = 0, k, i;
    always #25 clk_i = ~clk_i;
    // The address pushed at entry is the CPU's address at the last edge before the stall.
    always @(posedge clk_i)
        if (!cpu_halt_o)
            last_pc <= pc_i;
    isc_irq_sleep u_isc_irq_sleep (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(1'b1), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .ext_irq_pin_i(ext_irq_pin_i), .wdt_wake_i(1'b0), .timer_ovf_i(timer_ovf_i), .cmp_event_i(1'b0),
        .instr_done_i(instr_done_i), .pc_i(pc_i), .call_i(1'b0), .ret_i(1'b0), .irq_return_instruction_i(irq_return_instruction_i),
        .sleep_instr_i(sleep_instr_i), .cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o),
        .vector_valid_o(vector_valid_o), .vector_pc_o(vector_pc_o), .return_valid_o(return_valid_o),
        .return_pc_o(return_pc_o), .global_enable_o(global_enable_o));
    isc_cpu_model u_isc_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .halt_i(cpu_halt_o),
        .vec_valid_i(vector_valid_o), .vec_pc_i(vector_pc_o), .ret_valid_i(return_valid_o),
        .ret_pc_i(return_pc_o), .done_o(instr_done_i), .pc_o(pc_i));
    task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // The request is held until the edge at which ack or err is seen, then released.
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (!(ack_o || err_o) && k < 50);
        q = dat_o;
        erf = err_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        xfer(1'b0, a, 8'h00);
        chk(nm, {1'b0, e}, {1'b0, q});
    endtask
    task pls(input int w);
        @(posedge clk_i);
        {irq_return_instruction_i, sleep_instr_i, timer_ovf_i} <= 3'h1 << w;
        @(posedge clk_i);
        {irq_return_instruction_i, sleep_instr_i, timer_ovf_i} <= 3'h0;
    endtask
    task wt(input logic s);
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
            hit = s ? return_valid_o : vector_valid_o;
        end while (!hit && k < 40);
    endtask
    task rti;
        pls(2);
        wt(1'b1);
        chk("return_valid", 9'h001, {8'h00, hit});
        chk("return_pc", ret_exp, return_pc_o);
    endtask
    task vec(input logic [8:0] e);
        wt(1'b0);
        chk("vector_pc", e, hit ? vector_pc_o : 9'h1FF);
        if (hit)
            ret_exp = last_pc;
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The whole sequence needs under 3000 cycles; the limit leaves a wide margin.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("[FAIL] run_time expected finish seen timeout");
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 5; i++)
            rd(am[i], 8'h00, "reset_value");
        xfer(1'b0, 8'h20, 8'h00);
        chk("unmapped_err", 9'h001, {8'h00, erf});
        for (i = 0; i < 5; i++) begin
            xfer(1'b1, am[i], 8'hFF);
            rd(am[i], em[i], "access_mask");
        end
        for (i = 0; i < 5; i++)
            xfer(1'b1, am[i], 8'h00);
        $display("test 1 finished");
        pls(0);
        rd(8'h38, 8'h02, "ovf_set");
        xfer(1'b1, 8'h38, 8'h00);
        rd(8'h38, 8'h02, "ovf_write_zero");
        xfer(1'b1, 8'h38, 8'h02);
        rd(8'h38, 8'h00, "ovf_write_one");
        pls(0);
        xfer(1'b1, 8'h39, 8'h02);
        xfer(1'b1, 8'h3F, 8'h80);
        vec(9'h002);
        rd(8'h3F, 8'h00, "gie_at_entry");
        rd(8'h38, 8'h00, "ovf_auto_clear");
        rti;
        rd(8'h3F, 8'h80, "gie_after_return");
        $display("test 2 finished");
        slow <= 1'b1;
        xfer(1'b1, 8'h3F, 8'h00);
        pls(0);
        ext_irq_pin_i <= 1'b0;
        xfer(1'b1, 8'h3B, 8'h40);
        xfer(1'b1, 8'h3F, 8'h80);
        vec(9'h001);
        @(posedge clk_i) ext_irq_pin_i <= 1'b1;
        rti;
        vec(9'h002);
        rti;
        slow <= 1'b0;
        for (i = 0; i < 3; i++) begin
            xfer(1'b1, 8'h35, sv[i]);
            @(posedge clk_i) ext_irq_pin_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            ext_irq_pin_i <= 1'b1;
            vec(ev[i]);
            if (hit)
                rti;
        end
        xfer(1'b1, 8'h3B, 8'h00);
        xfer(1'b1, 8'h35, 8'h02);
        @(posedge clk_i) ext_irq_pin_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        ext_irq_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        xfer(1'b1, 8'h35, 8'h00);
        xfer(1'b1, 8'h35, 8'h02);
        xfer(1'b1, 8'h3B, 8'h40);
        vec(9'h1FF);
        $display("test 3 finished");
        xfer(1'b1, 8'h35, 8'h00);
        pls(1);
        wt(1'b1);
        chk("halt_no_enable", 9'h000, {8'h00, cpu_halt_o});
        xfer(1'b1, 8'h35, 8'h30);
        pls(1);
        wt(1'b1);
        chk("osc_stop", 9'h001, {8'h00, osc_stop_o});
        pls(0);
        wt(1'b1);
        chk("ovf_no_wake", 9'h001, {8'h00, osc_stop_o});
        xfer(1'b1, 8'h38, 8'h02);
        @(posedge clk_i) ext_irq_pin_i <= 1'b0;
        vec(9'h001);
        @(posedge clk_i) ext_irq_pin_i <= 1'b1;
        rti;
        pls(1);
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("halt_after_reset", 9'h000, {8'h00, cpu_halt_o});
        chk("restart_pc", 9'h000, pc_i);
        rd(8'h35, 8'h00, "ctrl_after_reset");
        $display("test 4 finished");
        end_of_test;
    end
endmodule // tb_isc_irq_sleep
